/* hw/csh_regs.svh */
/*
 constants of the console serial handshake: command codes, framing and timing.
 assumes it is included by bare name wherever a figure is needed.
*/
`ifndef CSH_REGS_SVH
`define CSH_REGS_SVH

// command bytes sent by the device
`define CSH_CMD_TEST 8'h7F
`define CSH_CMD_SHOW_CHAR 8'h59
`define CSH_CMD_SHOW_NUM8 8'h51
`define CSH_CMD_SHOW_NUM16 8'h52
`define CSH_CMD_SHOW_NUM32 8'h54
`define CSH_CMD_READ_CHAR 8'h69
`define CSH_CMD_READ_NUM8 8'h61
`define CSH_CMD_READ_NUM16 8'h62
`define CSH_CMD_READ_NUM32 8'h64

// reply bytes
`define CSH_REPLY_PRESENT 8'h8A
`define CSH_ACK 8'h90

// framing
`define CSH_DATA_BITS 8
`define CSH_FRAME_TAIL 4'h9

// timing
`define CSH_CLK_HZ 200000000
`define CSH_BAUD 9600
`define CSH_WAIT_MS 500
`define CSH_MS_PER_S 1000

`endif

/* hw/csh_pkg.sv */
/*
 types of the console serial handshake.
 assumes csh_regs.svh supplies all figures.
*/
package csh_pkg;

   // gray codes along idle, send, value, push
   typedef enum logic [2:0] {
      CSH_IDLE = 3'h0,
      CSH_SEND = 3'h1,
      CSH_GETVAL = 3'h3,
      CSH_PUSH = 3'h2,
      CSH_GETACK = 3'h6,
      CSH_GETUSER = 3'h4
   } csh_state_t;

   typedef struct packed {
      logic is_char;
      logic [2:0] bytes;
      logic [31:0] value;
   } csh_item_t;

   typedef struct packed {
      logic is_char;
      logic [2:0] bytes;
   } csh_kind_t;

endpackage : csh_pkg

/* hw/csh_buf.sv */
/*
 two-entry buffer with valid and ready on both sides; head is a register.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module csh_buf #(
   parameter int WIDTH = 36
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] tail;
   logic tail_valid;
   logic push;
   logic pop;

   // ready only while the tail slot is free, so a stalled reader loses nothing
   assign in_ready = !tail_valid;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         tail_valid <= 1'b0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (out_valid) tail_valid <= 1'b1;
               else out_valid <= 1'b1;
            end
            2'b01: begin
               out_valid <= tail_valid;
               tail_valid <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_data <= '0;
         tail <= '0;
      end else begin
         if (push && (!out_valid || (pop && !tail_valid))) out_data <= in_data;
         else if (pop) out_data <= tail;
         if (push && out_valid && !(pop && !tail_valid)) tail <= in_data;
      end
   end

endmodule : csh_buf

/* hw/csh_console.sv */
/*
 console end of the half-duplex serial handshake: answers the device's
 commands, hands shown items to the user and returns user input values.
 assumes a pull-up on the shared line outside and line_in synchronous.
*/
// Notes on behaviour
// - 9600 baud, 8 data, 1 stop, no parity
// - drive shared line only during own turn
// - multi-byte values travel most significant first
// - presence check 7F answered with 8A
// - 8-bit show: ack 90, then value byte
// - 16-bit show: ack before each byte
// - 32-bit show: ack before each byte
// - 8-bit read: reply value at once
// - 16-bit read: device acks second byte
// - 32-bit read: device acks remaining bytes
// - console replies fast, tight loops
`timescale 1ns/1ps
`include "csh_regs.svh"
module csh_console #(
   parameter int BIT_CYCLES = `CSH_CLK_HZ / `CSH_BAUD,
   parameter int WAIT_CYCLES = `CSH_CLK_HZ / `CSH_MS_PER_S * `CSH_WAIT_MS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   output logic disp_valid,
   output csh_pkg::csh_item_t disp_item,
   input wire logic disp_ready,
   output logic inp_req,
   output csh_pkg::csh_kind_t inp_kind,
   input wire logic inp_valid,
   input wire logic [31:0] inp_value,
   output logic inp_taken,
   output logic proto_err
);
   localparam int BW = $clog2(2 * BIT_CYCLES + 1);
   localparam int WW = $clog2(WAIT_CYCLES + 1);
   localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);
   localparam logic [BW-1:0] HALF_LAST = BW'(BIT_CYCLES / 2 - 1);
   localparam logic [BW-1:0] STOP_LAST = BW'(BIT_CYCLES + BIT_CYCLES / 2 - 1);

   csh_pkg::csh_state_t state;
   csh_pkg::csh_state_t after;
   csh_pkg::csh_kind_t kind;
   logic [2:0] left;
   logic [31:0] acc;
   logic [7:0] tx_byte;
   logic tx_go;
   logic tx_done;
   logic [8:0] tx_sh;
   logic [3:0] tx_n;
   logic [BW-1:0] tx_cnt;
   logic [1:0] rx_phase;
   logic [BW-1:0] rx_cnt;
   logic [2:0] rx_n;
   logic [7:0] rx_sh;
   logic [7:0] rx_byte;
   logic rx_strobe;
   logic [WW-1:0] wait_cnt;
   logic waiting;
   logic expired;
   logic user_in;
   logic buf_ready;

   // byte count of a command, zero when not a value command
   function automatic logic [2:0] csh_width(input logic [7:0] cmd);
      unique case (cmd)
         `CSH_CMD_SHOW_CHAR, `CSH_CMD_SHOW_NUM8,
         `CSH_CMD_READ_CHAR, `CSH_CMD_READ_NUM8: csh_width = 3'h1;
         `CSH_CMD_SHOW_NUM16, `CSH_CMD_READ_NUM16: csh_width = 3'h2;
         `CSH_CMD_SHOW_NUM32, `CSH_CMD_READ_NUM32: csh_width = 3'h4;
         default: csh_width = 3'h0;
      endcase
   endfunction : csh_width

   // left-justify a value so its top byte goes out first
   function automatic logic [31:0] csh_align(input logic [31:0] v, input logic [2:0] n);
      unique case (n)
         3'h1: csh_align = {v[7:0], 24'h000000};
         3'h2: csh_align = {v[15:0], 16'h0000};
         default: csh_align = v;
      endcase
   endfunction : csh_align

   // transmitter: enable high only for start, data and stop bits
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         line_out <= 1'b1;
         line_oe <= 1'b0;
         tx_sh <= 9'h1FF;
         tx_n <= 4'h0;
         tx_cnt <= '0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (!line_oe) begin
            if (tx_go) begin
               line_oe <= 1'b1;
               line_out <= 1'b0;
               tx_sh <= {1'b1, tx_byte};
               tx_n <= `CSH_FRAME_TAIL;
               tx_cnt <= BIT_LAST;
            end
         end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
         end else if (tx_n == 4'h0) begin
            line_oe <= 1'b0;
            line_out <= 1'b1;
            tx_done <= 1'b1;
         end else begin
            line_out <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[8:1]};
            tx_n <= tx_n - 1'b1;
            tx_cnt <= BIT_LAST;
         end
      end
   end

   // receiver: deaf while we drive, since our own frame echoes back
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_phase <= 2'h0;
         rx_cnt <= '0;
         rx_n <= 3'h0;
         rx_sh <= 8'h00;
         rx_byte <= 8'h00;
         rx_strobe <= 1'b0;
      end else begin
         rx_strobe <= 1'b0;
         if (line_oe || tx_go) begin
            rx_phase <= 2'h0;
         end else if (rx_phase == 2'h0) begin
            if (!line_in) begin
               rx_phase <= 2'h1;
               rx_cnt <= HALF_LAST;
            end
         end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
         end else if (rx_phase == 2'h1) begin
            rx_phase <= line_in ? 2'h0 : 2'h2;
            rx_cnt <= BIT_LAST;
            rx_n <= 3'h0;
         end else if (rx_phase == 2'h2) begin
            rx_sh <= {line_in, rx_sh[7:1]};
            rx_n <= rx_n + 1'b1;
            // stop checked at its end so our reply never overlaps it
            rx_cnt <= (rx_n == 3'h7) ? STOP_LAST : BIT_LAST;
            if (rx_n == 3'h7) rx_phase <= 2'h3;
         end else begin
            rx_phase <= 2'h0;
            rx_byte <= rx_sh;
            rx_strobe <= line_in;
         end
      end
   end

   // reply wait, matching the device's own half-second limit
   assign waiting = (state == csh_pkg::CSH_GETVAL) || (state == csh_pkg::CSH_GETACK)
      || (state == csh_pkg::CSH_GETUSER);
   assign user_in = (state == csh_pkg::CSH_GETUSER) && inp_valid;
   assign expired = waiting && (wait_cnt == '0);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt <= WW'(WAIT_CYCLES);
      end else if (waiting && !rx_strobe && !user_in && !expired) begin
         wait_cnt <= wait_cnt - 1'b1;
      end else begin
         wait_cnt <= WW'(WAIT_CYCLES);
      end
   end

   // exchange sequencer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= csh_pkg::CSH_IDLE;
         after <= csh_pkg::CSH_IDLE;
         kind <= '0;
         left <= 3'h0;
         acc <= 32'h00000000;
         tx_byte <= 8'h00;
         tx_go <= 1'b0;
         inp_req <= 1'b0;
         inp_kind <= '0;
         inp_taken <= 1'b0;
         proto_err <= 1'b0;
      end else begin
         tx_go <= 1'b0;
         inp_taken <= 1'b0;
         proto_err <= 1'b0;
         if (expired) begin
            state <= csh_pkg::CSH_IDLE;
            inp_req <= 1'b0;
            proto_err <= 1'b1;
         end else begin
            unique case (state)
               csh_pkg::CSH_IDLE: begin
                  // commands arrive here in free run too
                  if (rx_strobe) begin
                     kind <= '{is_char: rx_byte[3], bytes: csh_width(rx_byte)};
                     left <= csh_width(rx_byte);
                     acc <= 32'h00000000;
                     if (rx_byte == `CSH_CMD_TEST) begin
                        tx_byte <= `CSH_REPLY_PRESENT;
                        tx_go <= 1'b1;
                        after <= csh_pkg::CSH_IDLE;
                        state <= csh_pkg::CSH_SEND;
                     end else if (csh_width(rx_byte) == 3'h0) begin
                        proto_err <= 1'b1;
                     end else if (rx_byte[5]) begin
                        inp_req <= 1'b1;
                        inp_kind <= '{is_char: rx_byte[3], bytes: csh_width(rx_byte)};
                        state <= csh_pkg::CSH_GETUSER;
                     end else begin
                        tx_byte <= `CSH_ACK;
                        tx_go <= 1'b1;
                        after <= csh_pkg::CSH_GETVAL;
                        state <= csh_pkg::CSH_SEND;
                     end
                  end
               end
               csh_pkg::CSH_SEND: begin
                  if (tx_done) state <= after;
               end
               csh_pkg::CSH_GETVAL: begin
                  if (rx_strobe) begin
                     acc <= {acc[23:0], rx_byte};
                     left <= left - 1'b1;
                     if (left == 3'h1) begin
                        state <= csh_pkg::CSH_PUSH;
                     end else begin
                        tx_byte <= `CSH_ACK;
                        tx_go <= 1'b1;
                        after <= csh_pkg::CSH_GETVAL;
                        state <= csh_pkg::CSH_SEND;
                     end
                  end
               end
               csh_pkg::CSH_PUSH: begin
                  // a full buffer holds the sequencer here
                  if (buf_ready) state <= csh_pkg::CSH_IDLE;
               end
               csh_pkg::CSH_GETUSER: begin
                  if (inp_valid) begin
                     inp_req <= 1'b0;
                     inp_taken <= 1'b1;
                     acc <= {csh_align(inp_value, left) << 8};
                     tx_byte <= 8'(csh_align(inp_value, left) >> 24);
                     tx_go <= 1'b1;
                     left <= left - 1'b1;
                     after <= (left == 3'h1) ? csh_pkg::CSH_IDLE : csh_pkg::CSH_GETACK;
                     state <= csh_pkg::CSH_SEND;
                  end
               end
               csh_pkg::CSH_GETACK: begin
                  if (rx_strobe && rx_byte == `CSH_ACK) begin
                     tx_byte <= acc[31:24];
                     acc <= {acc[23:0], 8'h00};
                     tx_go <= 1'b1;
                     left <= left - 1'b1;
                     after <= (left == 3'h1) ? csh_pkg::CSH_IDLE : csh_pkg::CSH_GETACK;
                     state <= csh_pkg::CSH_SEND;
                  end else if (rx_strobe) begin
                     state <= csh_pkg::CSH_IDLE;
                     proto_err <= 1'b1;
                  end
               end
               default: state <= csh_pkg::CSH_IDLE;
            endcase
         end
      end
   end

   // shown items only; program images are never read back
   csh_buf #(.WIDTH($bits(csh_pkg::csh_item_t))) u_buf (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(state == csh_pkg::CSH_PUSH),
      .in_ready(buf_ready),
      .in_data({kind.is_char, kind.bytes, acc}),
      .out_valid(disp_valid),
      .out_ready(disp_ready),
      .out_data(disp_item)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_oe_turn;
      line_oe |-> state == csh_pkg::CSH_SEND;
   endproperty
   a_oe_turn: assert property (p_oe_turn) else $error("line driven outside send");

   property p_release_high;
      !line_oe |-> line_out;
   endproperty
   a_release_high: assert property (p_release_high) else $error("released line not high");

   property p_start_bit;
      $rose(line_oe) |-> !line_out [*8];
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit too short");

   property p_presence;
      state == csh_pkg::CSH_IDLE && rx_strobe && rx_byte == 8'h7F
         |=> state == csh_pkg::CSH_SEND && tx_go && tx_byte == 8'h8A;
   endproperty
   a_presence: assert property (p_presence) else $error("presence not answered");

   property p_show_ack;
      state == csh_pkg::CSH_IDLE && rx_strobe && (rx_byte == 8'h59 || rx_byte == 8'h51)
         |=> tx_byte == 8'h90 && after == csh_pkg::CSH_GETVAL && left == 3'h1;
   endproperty
   a_show_ack: assert property (p_show_ack) else $error("8-bit show not acked");

   property p_show_wide;
      state == csh_pkg::CSH_IDLE && rx_strobe && rx_byte == 8'h54 |=> left == 3'h4;
   endproperty
   a_show_wide: assert property (p_show_wide) else $error("32-bit show count wrong");

   property p_msb_first;
      state == csh_pkg::CSH_GETVAL && rx_strobe && !expired
         |=> acc == {$past(acc[23:0]), $past(rx_byte)};
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("value not shifted msb first");

   property p_read_direct;
      state == csh_pkg::CSH_IDLE && rx_strobe && rx_byte == 8'h69
         |=> inp_req && state == csh_pkg::CSH_GETUSER && inp_kind.bytes == 3'h1;
   endproperty
   a_read_direct: assert property (p_read_direct) else $error("read not requested");

   property p_ack_next;
      state == csh_pkg::CSH_GETACK && rx_strobe && rx_byte == 8'h90 && !expired
         |=> tx_go ##1 line_oe;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("byte not sent after ack");

   property p_expire;
      expired |=> state == csh_pkg::CSH_IDLE && proto_err && !inp_req;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry did not return idle");

endmodule : csh_console

/* dv/csh_dev_model.sv */
/*
 behavioural model of the device end of the half-duplex console link.
 assumes the bench resolves the shared line with a pull-up and calls its tasks.
*/
`timescale 1ns/1ps
module csh_dev_model #(
   parameter int BIT = 16,
   parameter int WAIT = 2000
) (
   input wire logic core_clk,
   input wire logic line,
   output logic dev_out,
   output logic dev_oe
);
   // console traffic only, no debug session kept
   // write-only path: no program readback request exists
   initial begin
      dev_out = 1'b1;
      dev_oe = 1'b0;
   end

   // 8n1 frame, lsb first, line held only for our own frame
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge core_clk);
      #1;
      dev_oe = 1'b1;
      for (int i = 0; i < 10; i++) begin
         dev_out = f[i];
         repeat (BIT) @(posedge core_clk);
         #1;
      end
      dev_oe = 1'b0;
      dev_out = 1'b1;
   endtask : send_byte

   // gives up after WAIT cycles without a start bit
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      n = 0;
      while (line !== 1'b0 && n < WAIT) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (line === 1'b0) begin
         repeat (BIT / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge core_clk);
            #1;
            b[i] = line;
         end
         repeat (BIT) @(posedge core_clk);
         #1;
         ok = (line === 1'b1);
         // let the stop bit finish before taking the line
         repeat (BIT / 2 + 2) @(posedge core_clk);
         // return off the edge so callers never race the console's outputs
         #1;
      end
   endtask : recv_byte
endmodule : csh_dev_model

/* dv/console_serial_handshake_bench.sv */
/*
 self-checking bench of the console end against the device model.
 assumes shortened bit and wait counts and a pull-up on the shared line.
*/
`timescale 1ns/1ps
module console_serial_handshake_bench;
   localparam int BIT = 16;
   localparam int WAIT = 2000;
   logic core_clk;
   logic reset_n;
   wire logic line;
   logic dut_out;
   logic dut_oe;
   logic dev_out;
   logic dev_oe;
   logic disp_valid;
   csh_pkg::csh_item_t disp_item;
   logic disp_ready;
   logic inp_req;
   csh_pkg::csh_kind_t inp_kind;
   logic inp_valid;
   logic [31:0] inp_value;
   logic inp_taken;
   logic proto_err;
   int err_total = 0;
   int checks = 0;
   int perr = 0;

   // pull-up: released line reads high
   assign line = (dut_oe === 1'b1 ? dut_out : 1'b1) & (dev_oe === 1'b1 ? dev_out : 1'b1);

   csh_console #(.BIT_CYCLES(BIT), .WAIT_CYCLES(WAIT)) i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .line_in(line), .line_out(dut_out),
      .line_oe(dut_oe), .disp_valid(disp_valid), .disp_item(disp_item),
      .disp_ready(disp_ready), .inp_req(inp_req), .inp_kind(inp_kind),
      .inp_valid(inp_valid), .inp_value(inp_value), .inp_taken(inp_taken),
      .proto_err(proto_err));

   csh_dev_model #(.BIT(BIT), .WAIT(WAIT)) i_dev (
      .core_clk(core_clk), .line(line), .dev_out(dev_out), .dev_oe(dev_oe));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (proto_err === 1'b1) begin
         perr++;
      end
   end

   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task automatic rx_check(input logic [7:0] exp);
      logic [7:0] b;
      logic ok;
      i_dev.recv_byte(b, ok);
      check(36'({ok, b}), 36'({1'b1, exp}));
   endtask : rx_check

   task automatic no_reply(input int perr_exp);
      logic [7:0] b;
      logic ok;
      i_dev.recv_byte(b, ok);
      check(36'(ok), 36'h0);
      check(36'(perr), 36'(perr_exp));
   endtask : no_reply

   task automatic show(input logic [7:0] cmd, input int n, input logic [31:0] v);
      i_dev.send_byte(cmd);
      for (int i = n - 1; i >= 0; i--) begin
         rx_check(8'h90);
         i_dev.send_byte(v[8 * i +: 8]);
      end
   endtask : show

   task automatic take(input logic [35:0] exp);
      int n;
      n = 0;
      while (disp_valid !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(36'(disp_valid), 36'h1);
      check(disp_item, exp);
      @(posedge core_clk);
      #1;
      disp_ready = 1'b1;
      @(posedge core_clk);
      #1;
      disp_ready = 1'b0;
   endtask : take

   task automatic read(input logic [7:0] cmd, input int n, input logic [31:0] v);
      int k;
      k = 0;
      i_dev.send_byte(cmd);
      while (inp_req !== 1'b1 && k < 100) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      check(36'(inp_req), 36'h1);
      check(36'(inp_kind), 36'({cmd == 8'h69, 3'(n)}));
      inp_value = v;
      inp_valid = 1'b1;
      @(posedge core_clk);
      #1;
      inp_valid = 1'b0;
      check(36'({inp_taken, inp_req}), 36'h2);
      for (int i = n - 1; i >= 0; i--) begin
         rx_check(v[8 * i +: 8]);
         if (i > 0) begin
            i_dev.send_byte(8'h90);
         end
      end
   endtask : read

   task automatic test_presence();
      i_dev.send_byte(8'h7F);
      rx_check(8'h8A);
      check(36'(dut_oe), 36'h0);
      $display("test presence done");
   endtask : test_presence

   // receiver stalls so two items sit in the buffer
   task automatic test_show();
      show(8'h51, 1, 32'h0000_00A5);
      show(8'h52, 2, 32'h0000_1234);
      take({1'b0, 3'h1, 32'h0000_00A5});
      take({1'b0, 3'h2, 32'h0000_1234});
      show(8'h54, 4, 32'hDEAD_BEEF);
      take({1'b0, 3'h4, 32'hDEAD_BEEF});
      show(8'h59, 1, 32'h0000_0041);
      take({1'b1, 3'h1, 32'h0000_0041});
      $display("test show done");
   endtask : test_show

   // upper bytes of the user value must not leak onto the line
   task automatic test_read();
      read(8'h69, 1, 32'hAABB_CC3C);
      read(8'h61, 1, 32'h1122_33C5);
      read(8'h62, 2, 32'hFFFF_A55A);
      read(8'h64, 4, 32'h0123_4567);
      $display("test read done");
   endtask : test_read

   task automatic test_faults();
      i_dev.send_byte(8'h33);
      no_reply(1);
      i_dev.send_byte(8'h62);
      inp_value = 32'h0000_1234;
      inp_valid = 1'b1;
      rx_check(8'h12);
      inp_valid = 1'b0;
      i_dev.send_byte(8'h55);
      no_reply(2);
      show(8'h52, 1, 32'h0000_0077);
      repeat (WAIT + 200) @(posedge core_clk);
      #1;
      check(36'(perr), 36'h3);
      check(36'({disp_valid, dut_oe}), 36'h0);
      test_presence();
      $display("test faults done");
   endtask : test_faults

   initial begin
      reset_n = 1'b0;
      disp_ready = 1'b0;
      inp_valid = 1'b0;
      inp_value = 32'h0000_0000;
      repeat (6) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      check(36'({dut_oe, dut_out, disp_valid, inp_req}), 36'h4);
      test_presence();
      test_show();
      test_read();
      test_faults();
      end_sim();
   end

   // whole run needs roughly 14000 cycles
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      end_sim();
   end
endmodule : console_serial_handshake_bench
